/* hdl/eag_pkg.sv */
// Package of constants and types for the effective address generator
package eag_pkg;

  localparam logic [7:0]  EAG_BANK_ZERO   = 8'h00;
  localparam logic [7:0]  EAG_VEC_PAGE    = 8'hFF;
  localparam logic [2:0]  EAG_VEC_TOP     = 3'h7;
  localparam logic [15:0] EAG_PC_RST      = 16'h0000;
  localparam logic [7:0]  EAG_PBR_RST     = 8'h00;
  localparam logic [23:0] EAG_ADDR_RST    = 24'h000000;
  localparam logic [15:0] EAG_OPND_RST    = 16'h0000;
  localparam logic [15:0] EAG_PC_STEP     = 16'h0001;

  typedef enum logic [3:0] {
    EAG_IMM        = 4'h0,
    EAG_ABS        = 4'h1,
    EAG_ABS_LONG   = 4'h2,
    EAG_DIR        = 4'h3,
    EAG_ACC        = 4'h4,
    EAG_IMPL       = 4'h5,
    EAG_DIR_IND_Y  = 4'h6,
    EAG_DIR_ILNG_Y = 4'h7,
    EAG_DIR_X_IND  = 4'h8,
    EAG_DIR_X      = 4'h9,
    EAG_DIR_Y      = 4'hA,
    EAG_ABS_X      = 4'hB,
    EAG_ABS_Y      = 4'hC,
    EAG_ABS_LONG_X = 4'hD,
    EAG_STACK      = 4'hE,
    EAG_STACK_REL  = 4'hF
  } eag_mode_t;

  typedef enum logic [1:0] {
    EAG_CYC_INTERNAL = 2'h0,
    EAG_CYC_PROGRAM  = 2'h1,
    EAG_CYC_DATA     = 2'h2,
    EAG_CYC_OPCODE   = 2'h3
  } eag_cycle_t;

  typedef enum logic [2:0] {
    EAG_XFER_NONE         = 3'h0,
    EAG_XFER_RETURN_INT   = 3'h1,
    EAG_XFER_LONG_RETURN  = 3'h2,
    EAG_XFER_LONG_JUMP    = 3'h3,
    EAG_XFER_LONG_CALL    = 3'h4,
    EAG_XFER_ABS_LONG_JMP = 3'h5,
    EAG_XFER_SHORT        = 3'h6
  } eag_xfer_t;

  typedef enum logic [1:0] {
    EAG_VEC_IDLE = 2'h0,
    EAG_VEC_LO   = 2'h1,
    EAG_VEC_HI   = 2'h2
  } eag_vec_state_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] dir_base;
    logic [7:0]  data_bank;
    logic        idx_wide;
    logic        acc_wide;
  } eag_regs_t;

  typedef struct packed {
    eag_mode_t  mode;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [7:0] byte4;
  } eag_instr_t;

endpackage

/* hdl/eag_index_add.sv */
// Adds an index of selectable width to a 24-bit base
`timescale 1ns/1ps
module eag_index_add (
  // Operands
  input  wire logic [23:0] base_i,
  input  wire logic [15:0] idx_i,
  input  wire logic        idx_wide_i,
  input  wire logic        wrap_bank_i,
  // Result
  output logic      [23:0] sum_o
);

  logic [15:0] idx_eff;
  logic [23:0] full_sum;
  logic [15:0] low_sum;

  // Narrow index ignores the high byte
  assign idx_eff  = idx_wide_i ? idx_i : {8'h00, idx_i[7:0]};
  // Carry runs into the bank byte for data sums
  assign full_sum = base_i + {8'h00, idx_eff};
  assign low_sum  = base_i[15:0] + idx_eff;
  // Bank-zero modes must never leak a carry upward
  assign sum_o    = wrap_bank_i ? {base_i[23:16], low_sum}
                                : full_sum;

endmodule

/* hdl/eag_addr_gen.sv */
// Effective address generator with bus cycle qualifiers
`timescale 1ns/1ps
module eag_addr_gen (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               nrst_i,
  // Register file view
  input  wire eag_pkg::eag_regs_t regs_i,
  // Address request
  input  wire logic               ea_req_i,
  input  wire eag_pkg::eag_instr_t instr_i,
  input  wire logic [23:0]        ptr_data_i,
  // Program counter control
  input  wire logic               pc_inc_i,
  input  wire logic               branch_taken_i,
  input  wire logic [7:0]         branch_off_i,
  input  wire logic               pc_load_i,
  input  wire eag_pkg::eag_xfer_t xfer_kind_i,
  input  wire logic [23:0]        pc_target_i,
  // Bus cycle control
  input  wire eag_pkg::eag_cycle_t cycle_kind_i,
  input  wire logic               vec_req_i,
  input  wire logic [3:0]         vec_sel_i,
  // Address results
  output logic      [23:0]        ea_addr_o,
  output logic      [23:0]        ptr_addr_o,
  output logic      [15:0]        operand_o,
  output logic                    ea_valid_o,
  output logic                    ea_has_addr_o,
  output logic                    extra_cycle_o,
  // Program counter
  output logic      [15:0]        pc_o,
  output logic      [7:0]         pbr_o,
  // Bus pins
  output logic      [23:0]        bus_addr_o,
  output logic                    data_address_valid_o,
  output logic                    program_address_valid_o,
  output logic                    vector_pull_n_o
);

  eag_pkg::eag_vec_state_t vec_state_r;
  eag_pkg::eag_vec_state_t vec_state_nxt;

  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0]  pbr_r;
  logic [7:0]  pbr_nxt;
  logic [3:0]  vec_sel_r;
  logic [3:0]  vec_sel_cur;

  logic [23:0] dir_sum;
  logic [23:0] ptr_sum;
  logic [23:0] ea_sum;
  logic [23:0] ea_base;
  logic [15:0] ea_idx;
  logic        ea_wrap;
  logic [23:0] ea_nxt;
  logic        has_addr_nxt;
  logic [15:0] operand_nxt;
  logic [23:0] vec_addr;
  logic [15:0] abs_word;
  logic        long_xfer;

  assign abs_word = {instr_i.byte3, instr_i.byte2};

  // Direct base plus offset, always in bank zero
  eag_index_add u_dir_add (
    .base_i      ({eag_pkg::EAG_BANK_ZERO, regs_i.dir_base}),
    .idx_i       ({8'h00, instr_i.byte2}),
    .idx_wide_i  (1'b1),
    .wrap_bank_i (1'b1),
    .sum_o       (dir_sum)
  );

  // Pointer address, indexed by X only for the indexed-indirect mode
  eag_index_add u_ptr_add (
    .base_i      (dir_sum),
    .idx_i       ((instr_i.mode == eag_pkg::EAG_DIR_X_IND) ?
                  regs_i.x : 16'h0000),
    .idx_wide_i  (regs_i.idx_wide),
    .wrap_bank_i (1'b1),
    .sum_o       (ptr_sum)
  );

  // Final effective address adder
  eag_index_add u_ea_add (
    .base_i      (ea_base),
    .idx_i       (ea_idx),
    .idx_wide_i  (regs_i.idx_wide),
    .wrap_bank_i (ea_wrap),
    .sum_o       (ea_sum)
  );

  // Base, index and wrap selection per addressing mode
  always_comb begin
    ea_base = eag_pkg::EAG_ADDR_RST;
    ea_idx  = 16'h0000;
    ea_wrap = 1'b0;
    case (instr_i.mode)
      eag_pkg::EAG_ABS: begin
        ea_base = {regs_i.data_bank, abs_word};
      end
      eag_pkg::EAG_ABS_LONG: begin
        ea_base = {instr_i.byte4, abs_word};
      end
      eag_pkg::EAG_DIR: begin
        ea_base = dir_sum;
        ea_wrap = 1'b1;
      end
      eag_pkg::EAG_DIR_IND_Y: begin
        ea_base = {regs_i.data_bank, ptr_data_i[15:0]};
        ea_idx  = regs_i.y;
      end
      eag_pkg::EAG_DIR_ILNG_Y: begin
        ea_base = ptr_data_i;
        ea_idx  = regs_i.y;
      end
      eag_pkg::EAG_DIR_X_IND: begin
        ea_base = {regs_i.data_bank, ptr_data_i[15:0]};
      end
      eag_pkg::EAG_DIR_X: begin
        ea_base = dir_sum;
        ea_idx  = regs_i.x;
        ea_wrap = 1'b1;
      end
      eag_pkg::EAG_DIR_Y: begin
        ea_base = dir_sum;
        ea_idx  = regs_i.y;
        ea_wrap = 1'b1;
      end
      eag_pkg::EAG_ABS_X: begin
        ea_base = {regs_i.data_bank, abs_word};
        ea_idx  = regs_i.x;
      end
      eag_pkg::EAG_ABS_Y: begin
        ea_base = {regs_i.data_bank, abs_word};
        ea_idx  = regs_i.y;
      end
      eag_pkg::EAG_ABS_LONG_X: begin
        ea_base = {instr_i.byte4, abs_word};
        ea_idx  = regs_i.x;
      end
      eag_pkg::EAG_STACK: begin
        ea_base = {eag_pkg::EAG_BANK_ZERO, regs_i.sp};
        ea_wrap = 1'b1;
      end
      eag_pkg::EAG_STACK_REL: begin
        // Offset is unsigned; the sum wraps inside bank zero
        ea_base = {eag_pkg::EAG_BANK_ZERO, regs_i.sp};
        ea_idx  = {8'h00, instr_i.byte2};
        ea_wrap = 1'b1;
      end
      default: begin
        ea_base = eag_pkg::EAG_ADDR_RST;
      end
    endcase
  end

  // Stack index always uses the full offset byte, not the index width
  always_comb begin
    ea_nxt = ea_sum;
    if (instr_i.mode == eag_pkg::EAG_STACK_REL) begin
      ea_nxt = {eag_pkg::EAG_BANK_ZERO,
                regs_i.sp + {8'h00, instr_i.byte2}};
    end
  end

  // Immediate and register modes carry no operand address
  always_comb begin
    has_addr_nxt = 1'b1;
    operand_nxt  = eag_pkg::EAG_OPND_RST;
    case (instr_i.mode)
      eag_pkg::EAG_IMM: begin
        has_addr_nxt = 1'b0;
        operand_nxt  = regs_i.acc_wide ? abs_word
                                       : {8'h00, instr_i.byte2};
      end
      eag_pkg::EAG_ACC: begin
        has_addr_nxt = 1'b0;
      end
      eag_pkg::EAG_IMPL: begin
        has_addr_nxt = 1'b0;
      end
      default: begin
        has_addr_nxt = 1'b1;
      end
    endcase
  end

  // Address results
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ea_addr_o     <= eag_pkg::EAG_ADDR_RST;
      ptr_addr_o    <= eag_pkg::EAG_ADDR_RST;
      operand_o     <= eag_pkg::EAG_OPND_RST;
      ea_valid_o    <= 1'b0;
      ea_has_addr_o <= 1'b0;
      extra_cycle_o <= 1'b0;
    end else begin
      // Results hold until the next request; only the strobe pulses
      ea_valid_o <= ea_req_i;
      if (ea_req_i) begin
        ea_addr_o     <= has_addr_nxt ? ea_nxt : eag_pkg::EAG_ADDR_RST;
        ptr_addr_o    <= ptr_sum;
        operand_o     <= operand_nxt;
        ea_has_addr_o <= has_addr_nxt;
        // Unaligned direct base costs one more cycle in every direct mode
        extra_cycle_o <= has_addr_nxt &&
                         (instr_i.mode == eag_pkg::EAG_DIR ||
                          instr_i.mode == eag_pkg::EAG_DIR_IND_Y ||
                          instr_i.mode == eag_pkg::EAG_DIR_ILNG_Y ||
                          instr_i.mode == eag_pkg::EAG_DIR_X_IND ||
                          instr_i.mode == eag_pkg::EAG_DIR_X ||
                          instr_i.mode == eag_pkg::EAG_DIR_Y) &&
                         (regs_i.dir_base[7:0] != 8'h00);
      end
    end
  end

  // Program bank changes only for the long transfers and returns
  assign long_xfer = (xfer_kind_i == eag_pkg::EAG_XFER_RETURN_INT) ||
                     (xfer_kind_i == eag_pkg::EAG_XFER_LONG_RETURN) ||
                     (xfer_kind_i == eag_pkg::EAG_XFER_LONG_JUMP) ||
                     (xfer_kind_i == eag_pkg::EAG_XFER_LONG_CALL) ||
                     (xfer_kind_i == eag_pkg::EAG_XFER_ABS_LONG_JMP);

  // Load beats branch, branch beats increment
  always_comb begin
    pc_nxt  = pc_r;
    pbr_nxt = pbr_r;
    if (pc_load_i) begin
      pc_nxt = pc_target_i[15:0];
      if (long_xfer) begin
        pbr_nxt = pc_target_i[23:16];
      end
    end else if (branch_taken_i) begin
      // PC already points at the next opcode; bank stays put
      pc_nxt = pc_r + {{8{branch_off_i[7]}}, branch_off_i};
    end else if (pc_inc_i) begin
      // Sixteen-bit wrap: code cannot run across a bank boundary
      pc_nxt = pc_r + eag_pkg::EAG_PC_STEP;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pc_r  <= eag_pkg::EAG_PC_RST;
      pbr_r <= eag_pkg::EAG_PBR_RST;
    end else begin
      pc_r  <= pc_nxt;
      pbr_r <= pbr_nxt;
    end
  end

  assign pc_o  = pc_r;
  assign pbr_o = pbr_r;

  // Vector read sequence: low byte then high byte
  always_comb begin
    vec_state_nxt = vec_state_r;
    case (vec_state_r)
      eag_pkg::EAG_VEC_IDLE: begin
        if (vec_req_i) begin
          vec_state_nxt = eag_pkg::EAG_VEC_LO;
        end
      end
      eag_pkg::EAG_VEC_LO: begin
        vec_state_nxt = eag_pkg::EAG_VEC_HI;
      end
      eag_pkg::EAG_VEC_HI: begin
        vec_state_nxt = eag_pkg::EAG_VEC_IDLE;
      end
      default: begin
        vec_state_nxt = eag_pkg::EAG_VEC_IDLE;
      end
    endcase
  end

  // Selection is captured once so a moving input cannot split the word
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      vec_state_r <= eag_pkg::EAG_VEC_IDLE;
      vec_sel_r   <= 4'h0;
    end else begin
      vec_state_r <= vec_state_nxt;
      if (vec_state_r == eag_pkg::EAG_VEC_IDLE && vec_req_i) begin
        vec_sel_r <= vec_sel_i;
      end
    end
  end

  // The low byte goes out on the request edge, before the capture lands
  always_comb begin
    vec_sel_cur = vec_sel_r;
    if (vec_state_r == eag_pkg::EAG_VEC_IDLE) begin
      vec_sel_cur = vec_sel_i;
    end
  end

  // Vector word sits in the top 32 bytes of bank zero
  assign vec_addr = {eag_pkg::EAG_BANK_ZERO, eag_pkg::EAG_VEC_PAGE,
                     eag_pkg::EAG_VEC_TOP, vec_sel_cur,
                     (vec_state_nxt == eag_pkg::EAG_VEC_HI)};

  // Bus pins; a vector read overrides the requested cycle kind
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      bus_addr_o              <= eag_pkg::EAG_ADDR_RST;
      data_address_valid_o    <= 1'b0;
      program_address_valid_o <= 1'b0;
      vector_pull_n_o         <= 1'b1;
    end else if (vec_state_nxt != eag_pkg::EAG_VEC_IDLE) begin
      bus_addr_o              <= vec_addr;
      data_address_valid_o    <= 1'b1;
      program_address_valid_o <= 1'b0;
      vector_pull_n_o         <= 1'b0;
    end else begin
      vector_pull_n_o <= 1'b1;
      case (cycle_kind_i)
        eag_pkg::EAG_CYC_PROGRAM: begin
          bus_addr_o              <= {pbr_r, pc_r};
          data_address_valid_o    <= 1'b0;
          program_address_valid_o <= 1'b1;
        end
        eag_pkg::EAG_CYC_OPCODE: begin
          bus_addr_o              <= {pbr_r, pc_r};
          data_address_valid_o    <= 1'b1;
          program_address_valid_o <= 1'b1;
        end
        eag_pkg::EAG_CYC_DATA: begin
          bus_addr_o              <= ea_addr_o;
          data_address_valid_o    <= 1'b1;
          program_address_valid_o <= 1'b0;
        end
        default: begin
          // Address left as is; outside logic must not trust it
          data_address_valid_o    <= 1'b0;
          program_address_valid_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* dv/eag_addr_gen_sva.sv */
// Port-level assertions for the effective address generator
`timescale 1ns/1ps
module eag_addr_gen_sva (
  // Clock and reset
  input wire logic                core_clk_i,
  input wire logic                nrst_i,
  // Inputs
  input wire eag_pkg::eag_regs_t  regs_i,
  input wire logic                ea_req_i,
  input wire eag_pkg::eag_instr_t instr_i,
  input wire logic                pc_inc_i,
  input wire logic                branch_taken_i,
  input wire logic [7:0]          branch_off_i,
  input wire logic                pc_load_i,
  input wire eag_pkg::eag_xfer_t  xfer_kind_i,
  input wire logic [23:0]         pc_target_i,
  input wire eag_pkg::eag_cycle_t cycle_kind_i,
  input wire logic                vec_req_i,
  // Outputs
  input wire logic [23:0]         ea_addr_o,
  input wire logic                ea_has_addr_o,
  input wire logic                extra_cycle_o,
  input wire logic [15:0]         pc_o,
  input wire logic [7:0]          pbr_o,
  input wire logic [23:0]         bus_addr_o,
  input wire logic                data_address_valid_o,
  input wire logic                program_address_valid_o,
  input wire logic                vector_pull_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_vec_start;
    vec_req_i && vector_pull_n_o;
  endsequence
  sequence s_pull_two;
    !vector_pull_n_o [*2] ##1 vector_pull_n_o;
  endsequence

  // Vector cycles ignore the cycle kind, so they are kept out here
  a_qual_code: assert property (
    vector_pull_n_o && !vec_req_i |=> $past(cycle_kind_i) ==
    {data_address_valid_o, program_address_valid_o})
    else $error("qualifier pair wrong");
  a_vec_pull: assert property (
    s_vec_start |=> s_pull_two) else $error("vector pull width wrong");
  a_data_bus: assert property (
    vector_pull_n_o && !vec_req_i && cycle_kind_i == eag_pkg::EAG_CYC_DATA
    |=> bus_addr_o == $past(ea_addr_o)) else $error("data address wrong");
  a_pc_wrap: assert property (
    pc_inc_i && !branch_taken_i && !pc_load_i
    |=> pc_o == $past(pc_o) + 16'h0001 && $stable(pbr_o))
    else $error("increment wrong");
  a_branch_rel: assert property (
    branch_taken_i && !pc_load_i |=> $stable(pbr_o)
    && pc_o == $past(pc_o) + 16'($signed($past(branch_off_i))))
    else $error("branch target wrong");
  a_bank_load: assert property (
    pc_load_i |=> pc_o == $past(pc_target_i[15:0]) && pbr_o ==
    ($past(xfer_kind_i) inside {[1:5]} ? $past(pc_target_i[23:16])
    : $past(pbr_o))) else $error("program bank load wrong");
  a_bank_zero: assert property (
    ea_req_i && instr_i.mode inside {4'h3, 4'h9, 4'hA, 4'hE, 4'hF}
    |=> ea_addr_o[23:16] == 8'h00) else $error("bank not zero");
  a_no_addr: assert property (
    ea_req_i |=> ea_has_addr_o ==
    !($past(instr_i.mode) inside {4'h0, 4'h4, 4'h5}))
    else $error("address flag wrong");
  a_dir_extra: assert property (
    ea_req_i && instr_i.mode == eag_pkg::EAG_DIR |=> extra_cycle_o ==
    ($past(regs_i.dir_base[7:0]) != 8'h00)) else $error("extra cycle wrong");
endmodule

bind eag_addr_gen eag_addr_gen_sva u_eag_addr_gen_sva (.*);

/* dv/eag_mem_decode.sv */
// Model of the memory and I/O decoder on the address bus
`timescale 1ns/1ps
module eag_mem_decode (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Bus from the generator
  input  wire logic [23:0] bus_addr_i,
  input  wire logic        data_valid_i,
  input  wire logic        program_valid_i,
  // Decoded accesses
  output logic      [23:0] last_addr_o,
  output logic      [15:0] n_access_o
);
  // Internal cycles may carry a stale address, so they never decode
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      last_addr_o <= 24'h000000;
      n_access_o  <= 16'h0000;
    end else if (data_valid_i || program_valid_i) begin
      last_addr_o <= bus_addr_i;
      n_access_o  <= n_access_o + 16'h0001;
    end
  end
endmodule

/* dv/eag_addr_gen_tb.sv */
// Self-checking testbench for the effective address generator
`timescale 1ns/1ps
module eag_addr_gen_tb;
  logic                core_clk_i = 1'b0;
  logic                nrst_i = 1'b0;
  eag_pkg::eag_regs_t  regs_i = '{16'h1234, 16'h00F0, 16'h01F0, 16'hFF10,
                                   8'h7F, 1'b1, 1'b1};
  logic                ea_req_i = 1'b0;
  eag_pkg::eag_instr_t instr_i = '0;
  logic [23:0]         ptr_data_i = 24'h12FFF0;
  logic                pc_inc_i = 1'b0;
  logic                branch_taken_i = 1'b0;
  logic [7:0]          branch_off_i = 8'h00;
  logic                pc_load_i = 1'b0;
  eag_pkg::eag_xfer_t  xfer_kind_i = eag_pkg::EAG_XFER_NONE;
  logic [23:0]         pc_target_i = 24'h000000;
  eag_pkg::eag_cycle_t cycle_kind_i = eag_pkg::EAG_CYC_INTERNAL;
  logic                vec_req_i = 1'b0;
  logic [3:0]          vec_sel_i = 4'h0;
  logic [23:0]         ea_addr_o, ptr_addr_o, bus_addr_o, last_addr;
  logic [15:0]         operand_o, pc_o, n_access;
  logic [7:0]          pbr_o;
  logic                ea_valid_o, ea_has_addr_o, extra_cycle_o;
  logic                data_address_valid_o, program_address_valid_o;
  logic                vector_pull_n_o;
  logic [23:0]         pc_exp, ea_exp;
  logic [7:0]          bank = 8'hAB;
  int                  n_errors = 0;
  int                  total_checks = 0;
  int                  cycles = 0;

  eag_addr_gen u_eag_addr_gen (.*);
  eag_mem_decode u_eag_mem_decode (
    .core_clk_i      (core_clk_i),
    .nrst_i          (nrst_i),
    .bus_addr_i      (bus_addr_o),
    .data_valid_i    (data_address_valid_o),
    .program_valid_i (program_address_valid_o),
    .last_addr_o     (last_addr),
    .n_access_o      (n_access)
  );

  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic conclude;
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic mode(input logic [3:0] m, input logic [7:0] b2, b3, b4,
                      input logic [23:0] exp);
    @(posedge core_clk_i);
    ea_req_i <= 1'b1;
    instr_i  <= '{eag_pkg::eag_mode_t'(m), b2, b3, b4};
    #1;
    chk("ea_valid", 24'h0, {23'h0, ea_valid_o});
    @(posedge core_clk_i);
    ea_req_i <= 1'b0;
    #1;
    chk("ea_addr", exp, ea_addr_o);
    chk("ea_valid", 24'h1, {23'h0, ea_valid_o});
    chk("has_addr", {23'h0, !(m inside {4'h0, 4'h4, 4'h5})},
        {23'h0, ea_has_addr_o});
    ea_exp = exp;
  endtask

  task automatic pcstep(input logic [2:0] ctl, k, input logic [23:0] tgt,
                        input logic [7:0] off, input logic [23:0] exp);
    @(posedge core_clk_i);
    {pc_load_i, branch_taken_i, pc_inc_i} <= ctl;
    xfer_kind_i  <= eag_pkg::eag_xfer_t'(k);
    pc_target_i  <= tgt;
    branch_off_i <= off;
    @(posedge core_clk_i);
    {pc_load_i, branch_taken_i, pc_inc_i} <= 3'h0;
    #1;
    chk("pc", exp, {pbr_o, pc_o});
    pc_exp = exp;
  endtask

  task automatic buscyc(input logic [1:0] k, input logic [23:0] exp);
    @(posedge core_clk_i);
    cycle_kind_i <= eag_pkg::eag_cycle_t'(k);
    @(posedge core_clk_i);
    cycle_kind_i <= eag_pkg::EAG_CYC_INTERNAL;
    #1;
    chk("qualifiers", {22'h0, k},
        {22'h0, data_address_valid_o, program_address_valid_o});
    chk("bus_addr", exp, bus_addr_o);
  endtask

  // An opcode request rides along to show vector cycles ignore it
  task automatic vec(input logic [3:0] sel);
    @(posedge core_clk_i);
    vec_req_i    <= 1'b1;
    vec_sel_i    <= sel;
    cycle_kind_i <= eag_pkg::EAG_CYC_OPCODE;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_i);
      vec_req_i    <= 1'b0;
      cycle_kind_i <= (i == 1) ? eag_pkg::EAG_CYC_INTERNAL : cycle_kind_i;
      #1;
      chk("vec_pull", {23'h0, i == 2}, {23'h0, vector_pull_n_o});
      if (i < 2) begin
        chk("vec_addr", 24'h00FFE0 + {19'h0, sel, 1'b0} + 24'(i),
            bus_addr_o);
        chk("vec_qual", 24'h2,
            {22'h0, data_address_valid_o, program_address_valid_o});
      end
    end
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    repeat (7) @(posedge core_clk_i);
    buscyc(2'h0, 24'h000000);
    @(posedge core_clk_i);
    nrst_i <= 1'b1;
    mode(4'h0, 8'hCD, 8'hAB, 8'h00, 24'h000000);
    chk("operand", 24'h00ABCD, {8'h00, operand_o});
    mode(4'h1, 8'h34, 8'h12, 8'h00, 24'h7F1234);
    mode(4'h2, 8'h34, 8'h12, 8'hAB, 24'hAB1234);
    mode(4'h3, 8'hF5, 8'h00, 8'h00, 24'h000005);
    chk("extra", 24'h1, {23'h0, extra_cycle_o});
    mode(4'h4, 8'h00, 8'h00, 8'h00, 24'h000000);
    mode(4'h5, 8'h00, 8'h00, 8'h00, 24'h000000);
    mode(4'h6, 8'hF5, 8'h00, 8'h00, 24'h8000E0);
    mode(4'h7, 8'hF5, 8'h00, 8'h00, 24'h1300E0);
    mode(4'h8, 8'hF5, 8'h00, 8'h00, 24'h7FFFF0);
    chk("ptr_addr", 24'h001239, ptr_addr_o);
    mode(4'h9, 8'hF5, 8'h00, 8'h00, 24'h001239);
    mode(4'hA, 8'hF5, 8'h00, 8'h00, 24'h0000F5);
    mode(4'hB, 8'h00, 8'hFF, 8'h00, 24'h801134);
    mode(4'hC, 8'h00, 8'hFF, 8'h00, 24'h7FFFF0);
    mode(4'hD, 8'h00, 8'hFF, 8'hAB, 24'hAC1134);
    mode(4'hF, 8'hF5, 8'h00, 8'h00, 24'h0002E5);
    mode(4'hE, 8'h00, 8'h00, 8'h00, 24'h0001F0);
    @(posedge core_clk_i);
    regs_i <= '{16'h1234, 16'h00F0, 16'h01F0, 16'hFF00, 8'h7F, 1'b0, 1'b0};
    mode(4'h0, 8'hCD, 8'hAB, 8'h00, 24'h000000);
    chk("operand", 24'h0000CD, {8'h00, operand_o});
    mode(4'h3, 8'hF5, 8'h00, 8'h00, 24'h00FFF5);
    chk("extra", 24'h0, {23'h0, extra_cycle_o});
    mode(4'hB, 8'h00, 8'hFF, 8'h00, 24'h7FFF34);
    mode(4'h9, 8'hF5, 8'h00, 8'h00, 24'h000029);
    pcstep(3'h4, 3'h5, 24'hABFFFE, 8'h00, 24'hABFFFE);
    pcstep(3'h1, 3'h0, 24'h000000, 8'h00, 24'hABFFFF);
    pcstep(3'h1, 3'h0, 24'h000000, 8'h00, 24'hAB0000);
    pcstep(3'h3, 3'h0, 24'h000000, 8'h80, 24'hABFF80);
    pcstep(3'h2, 3'h0, 24'h000000, 8'h7F, 24'hABFFFF);
    for (int k = 0; k < 7; k++) begin
      bank = (k >= 1 && k <= 5) ? 8'h10 + 8'(k) : bank;
      pcstep(3'h4, 3'(k), {8'h10 + 8'(k), 16'h1230 + 16'(k)}, 8'h00,
             {bank, 16'h1230 + 16'(k)});
    end
    buscyc(2'h1, pc_exp);
    buscyc(2'h2, ea_exp);
    buscyc(2'h3, pc_exp);
    buscyc(2'h0, pc_exp);
    chk("decoded", pc_exp, last_addr);
    chk("accesses", 24'h3, {8'h00, n_access});
    vec(4'h0);
    vec(4'hE);
    vec(4'hF);
    conclude();
  end
endmodule
